// ### shared/btmc_params.svh
`ifndef BTMC_PARAMS_SVH
`define BTMC_PARAMS_SVH

// implementation clock
`define BTMC_CLK_NS 50
// power-up preset pulse length
`define BTMC_PRESET_US 100
`define BTMC_PRESET_CYC ((`BTMC_PRESET_US * 1000 + `BTMC_CLK_NS - 1) / `BTMC_CLK_NS)
`define BTMC_PRESET_CNT_W 12

// command lines: two per function in three-line option
`define BTMC_LINES 2
// two-line option uses line 0 of forward and reverse
`define BTMC_DC_LINE 0

// direction latch outputs, order {e, f, k}
`define BTMC_DIR_FWD_RUN 3'h1
`define BTMC_DIR_FWD_STOP 3'h5
`define BTMC_DIR_REV_RUN 3'h4
`define BTMC_DIR_REV_STOP 3'h7
`define BTMC_DIR_E 2
`define BTMC_DIR_F 1
`define BTMC_DIR_K 0

// coil terminals {high side, low side}
`define BTMC_COIL_ON 2'h2
`define BTMC_COIL_OFF 2'h3

`endif

// ### shared/btmc_pkg.sv
package btmc_pkg;

  typedef enum logic [1:0] {
    MOT_FWD_STOP,
    MOT_FWD_RUN,
    MOT_REV_RUN,
    MOT_REV_STOP
  } btmc_motion_e;

  typedef logic [1:0] btmc_coil_t;

  typedef struct packed {
    btmc_coil_t fwd_drive;
    btmc_coil_t fwd_brake;
    btmc_coil_t rev_drive;
    btmc_coil_t rev_brake;
  } btmc_coil_s;

  typedef struct packed {
    logic fwd;
    logic rev;
    logic stop;
  } btmc_cmd_s;

endpackage

// ### design/btmc_coil_driver.sv
`timescale 1ns/100ps
`include "btmc_params.svh"

module btmc_coil_driver (
  input wire logic clk, // implementation clock
  input wire logic nrst, // async reset, active low
  input wire logic [2:0] dir_lines, // direction latch {e, f, k}
  output btmc_pkg::btmc_coil_s coils // solenoid terminal pairs
);

  btmc_pkg::btmc_coil_s coils_reg;
  btmc_pkg::btmc_coil_s coils_next;

  // exactly one coil per latch code; unknown codes release everything
  always_comb begin
    coils_next.fwd_drive = `BTMC_COIL_OFF;
    coils_next.fwd_brake = `BTMC_COIL_OFF;
    coils_next.rev_drive = `BTMC_COIL_OFF;
    coils_next.rev_brake = `BTMC_COIL_OFF;
    case (dir_lines)
      `BTMC_DIR_FWD_RUN: coils_next.fwd_drive = `BTMC_COIL_ON;
      `BTMC_DIR_FWD_STOP: coils_next.fwd_brake = `BTMC_COIL_ON;
      `BTMC_DIR_REV_RUN: coils_next.rev_drive = `BTMC_COIL_ON;
      `BTMC_DIR_REV_STOP: coils_next.rev_brake = `BTMC_COIL_ON;
      default: coils_next.fwd_drive = `BTMC_COIL_OFF;
    endcase
  end

  // idle coils sit at both terminals high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coils_reg <= {4{`BTMC_COIL_OFF}};
    end else begin
      coils_reg <= coils_next;
    end
  end

  assign coils = coils_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // coil register is still idle on the first edge out of reset
  fwd_brake_only_a: assert property (
    $past(nrst) && $past(dir_lines) == `BTMC_DIR_FWD_STOP |->
      coils == {`BTMC_COIL_OFF, `BTMC_COIL_ON, `BTMC_COIL_OFF, `BTMC_COIL_OFF})
    else $error("forward stop must energize forward brake only");

  rev_drive_only_a: assert property (
    $past(dir_lines) == `BTMC_DIR_REV_RUN |->
      coils == {`BTMC_COIL_OFF, `BTMC_COIL_OFF, `BTMC_COIL_ON, `BTMC_COIL_OFF})
    else $error("reverse run must energize reverse drive only");

  rev_brake_only_a: assert property (
    $past(dir_lines) == `BTMC_DIR_REV_STOP |->
      coils == {`BTMC_COIL_OFF, `BTMC_COIL_OFF, `BTMC_COIL_OFF, `BTMC_COIL_ON})
    else $error("reverse stop must energize reverse brake only");

  fwd_drive_only_a: assert property (
    $past(dir_lines) == `BTMC_DIR_FWD_RUN |->
      coils == {`BTMC_COIL_ON, `BTMC_COIL_OFF, `BTMC_COIL_OFF, `BTMC_COIL_OFF})
    else $error("forward run must energize forward drive only");

  coil_terminals_a: assert property (
    (coils.fwd_drive inside {`BTMC_COIL_ON, `BTMC_COIL_OFF}) &&
    (coils.fwd_brake inside {`BTMC_COIL_ON, `BTMC_COIL_OFF}) &&
    (coils.rev_drive inside {`BTMC_COIL_ON, `BTMC_COIL_OFF}) &&
    (coils.rev_brake inside {`BTMC_COIL_ON, `BTMC_COIL_OFF}))
    else $error("coil terminal pair in illegal state");

  single_coil_a: assert property (
    $onehot0({coils.fwd_drive == `BTMC_COIL_ON, coils.fwd_brake == `BTMC_COIL_ON,
              coils.rev_drive == `BTMC_COIL_ON, coils.rev_brake == `BTMC_COIL_ON}))
    else $error("more than one solenoid energized");

endmodule

// ### design/btmc_motion_ctrl.sv
// Operation
// - stop line low feeds run/stop latch only
// - stop sets run 0, stop 1
// - direction latch keeps direction through stop
// - forward stop gives direction outputs 1,0,1
// - forward stop energizes forward brake only
// - 100 us power-up preset forces stop
// - reverse line low feeds both latches
// - reverse command sets run 1, stop 0
// - reverse run gives direction outputs 1,0,0
// - reverse run energizes reverse drive only
// - reverse stop keeps reverse, outputs 1,1,1
// - reverse stop energizes reverse brake only
// - three-line forward run energizes forward drive only
// - energize: low terminal 0; idle: both 1
// - two-line forward gives run 1, stop 0
// - two-line forward gives direction outputs 0,0,1
// - two-line both high gives run 0, stop 1
// - two-line forward run energizes forward drive only
// - level run/stop stage follows input, never latches
// - forward line low sets run, outputs 0,0,1
`timescale 1ns/100ps
`include "btmc_params.svh"

module btmc_motion_ctrl #(
  parameter int PRESET_CYC = `BTMC_PRESET_CYC, // preset pulse length in cycles
  parameter int CNT_W = `BTMC_PRESET_CNT_W, // preset counter width
  parameter int LINES = `BTMC_LINES // command lines per function
) (
  input wire logic clk, // implementation clock, 20 MHz
  input wire logic nrst, // async reset, active low
  input wire logic two_line_mode, // 1: two dc line option
  input wire logic [LINES-1:0] fwd_n, // forward command lines, active low
  input wire logic [LINES-1:0] rev_n, // reverse command lines, active low
  input wire logic [LINES-1:0] stop_n, // stop command lines, active low
  output logic run_line, // run/stop latch run output
  output logic stop_line, // run/stop latch stop output
  output logic [2:0] dir_lines, // direction latch {e, f, k}
  output logic preset_busy, // power-up preset in progress
  output btmc_pkg::btmc_coil_s coils // solenoid terminal pairs
);

  localparam int SYNC_W = 3 * LINES + 1;
  localparam logic [CNT_W-1:0] PRESET_END = CNT_W'(PRESET_CYC);

  // two-stage synchronizer for all command lines and the option strap
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync1_next;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync2_next;

  always_comb begin
    sync1_next = {two_line_mode, fwd_n, rev_n, stop_n};
    sync2_next = sync1_reg;
  end

  // idle lines are high, so flops come out of reset at all ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= {SYNC_W{1'b1}};
      sync2_reg <= {SYNC_W{1'b1}};
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic mode_two;
  logic [LINES-1:0] fwd_s_n;
  logic [LINES-1:0] rev_s_n;
  logic [LINES-1:0] stop_s_n;

  assign {mode_two, fwd_s_n, rev_s_n, stop_s_n} = sync2_reg;

  // command input amplifier: any line low is an active command in three-line option; two-line reads line 0 only
  btmc_pkg::btmc_cmd_s cmd;
  logic dc_fwd;
  logic dc_rev;

  always_comb begin
    cmd.fwd = ~&fwd_s_n;
    cmd.rev = ~&rev_s_n;
    cmd.stop = ~&stop_s_n;
    dc_fwd = ~fwd_s_n[`BTMC_DC_LINE];
    dc_rev = ~rev_s_n[`BTMC_DC_LINE];
  end

  // power-up preset; runs once after reset release only
  logic [CNT_W-1:0] preset_cnt_reg;
  logic [CNT_W-1:0] preset_cnt_next;

  assign preset_busy = preset_cnt_reg != PRESET_END;

  always_comb begin
    preset_cnt_next = preset_cnt_reg;
    if (preset_busy) begin
      preset_cnt_next = preset_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      preset_cnt_reg <= '0;
    end else begin
      preset_cnt_reg <= preset_cnt_next;
    end
  end

  // run/stop latch and direction latch held as one motion state
  btmc_pkg::btmc_motion_e motion_reg;
  btmc_pkg::btmc_motion_e motion_next;
  btmc_pkg::btmc_motion_e motion_stop;

  // stopping never touches direction
  always_comb begin
    case (motion_reg)
      btmc_pkg::MOT_REV_RUN: motion_stop = btmc_pkg::MOT_REV_STOP;
      btmc_pkg::MOT_REV_STOP: motion_stop = btmc_pkg::MOT_REV_STOP;
      default: motion_stop = btmc_pkg::MOT_FWD_STOP;
    endcase
  end

  always_comb begin
    motion_next = motion_reg;
    if (preset_busy) begin
      motion_next = motion_stop;
    end else if (mode_two) begin
      // level stage: no memory of run, only of direction
      if (dc_fwd && !dc_rev) begin
        motion_next = btmc_pkg::MOT_FWD_RUN;
      end else if (dc_rev && !dc_fwd) begin
        motion_next = btmc_pkg::MOT_REV_RUN;
      end else begin
        motion_next = motion_stop;
      end
    end else begin
      // stop outranks run; fwd and rev together are ignored
      if (cmd.stop) begin
        motion_next = motion_stop;
      end else if (cmd.fwd && !cmd.rev) begin
        motion_next = btmc_pkg::MOT_FWD_RUN;
      end else if (cmd.rev && !cmd.fwd) begin
        motion_next = btmc_pkg::MOT_REV_RUN;
      end else begin
        motion_next = motion_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motion_reg <= btmc_pkg::MOT_FWD_STOP;
    end else begin
      motion_reg <= motion_next;
    end
  end

  logic rev_dir;

  assign run_line = (motion_reg == btmc_pkg::MOT_FWD_RUN) ||
                    (motion_reg == btmc_pkg::MOT_REV_RUN);
  assign stop_line = ~run_line;
  assign rev_dir = (motion_reg == btmc_pkg::MOT_REV_RUN) ||
                   (motion_reg == btmc_pkg::MOT_REV_STOP);

  // e low only in forward run; f is the nor of run and forward; k low only in reverse run
  assign dir_lines[`BTMC_DIR_E] = ~run_line | rev_dir;
  assign dir_lines[`BTMC_DIR_F] = ~(run_line | ~rev_dir);
  assign dir_lines[`BTMC_DIR_K] = ~(run_line & rev_dir);

  btmc_coil_driver u_coil_driver (
    .clk(clk),
    .nrst(nrst),
    .dir_lines(dir_lines),
    .coils(coils)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence live_s;
    !preset_busy;
  endsequence

  sequence stop_req_s;
    live_s and (!mode_two && cmd.stop);
  endsequence

  sequence fwd_req_s;
    live_s and (!mode_two && !cmd.stop && cmd.fwd && !cmd.rev);
  endsequence

  sequence rev_req_s;
    live_s and (!mode_two && !cmd.stop && cmd.rev && !cmd.fwd);
  endsequence

  sequence dc_fwd_s;
    live_s and (mode_two && dc_fwd && !dc_rev);
  endsequence

  sequence dc_idle_s;
    live_s and (mode_two && !dc_fwd && !dc_rev);
  endsequence

  stop_clears_run_a: assert property (
    stop_req_s |=> stop_line && !run_line)
    else $error("stop command did not stop the tape");

  stop_keeps_dir_a: assert property (
    (stop_req_s or (live_s and mode_two && dc_fwd == dc_rev)) |=> $stable(rev_dir))
    else $error("stop changed the direction");

  fwd_stop_code_a: assert property (
    (motion_reg == btmc_pkg::MOT_FWD_RUN) ##0 stop_req_s |=>
      dir_lines == `BTMC_DIR_FWD_STOP)
    else $error("forward stop direction outputs wrong");

  rev_stop_code_a: assert property (
    (motion_reg == btmc_pkg::MOT_REV_RUN) ##0 stop_req_s |=>
      dir_lines == `BTMC_DIR_REV_STOP)
    else $error("reverse stop direction outputs wrong");

  rev_run_code_a: assert property (
    rev_req_s |=> run_line && dir_lines == `BTMC_DIR_REV_RUN)
    else $error("reverse command did not select reverse run");

  fwd_run_code_a: assert property (
    fwd_req_s |=> run_line && dir_lines == `BTMC_DIR_FWD_RUN)
    else $error("forward command did not select forward run");

  dc_fwd_run_a: assert property (
    dc_fwd_s |=> run_line && dir_lines == `BTMC_DIR_FWD_RUN)
    else $error("two-line forward did not select forward run");

  dc_level_stop_a: assert property (
    run_line && mode_two ##0 dc_idle_s |=> stop_line)
    else $error("level stage held run after input removed");

  preset_forces_stop_a: assert property (
    preset_busy |=> stop_line)
    else $error("preset did not hold stop");

  preset_length_a: assert property (
    $fell(preset_busy) |-> $past(preset_cnt_reg) == PRESET_END - 1'b1)
    else $error("preset pulse length wrong");

  cmd_to_coil_a: assert property (
    rev_req_s ##1 live_s |=> coils.rev_drive == `BTMC_COIL_ON)
    else $error("reverse drive not energized two cycles after command");

endmodule

// ### sim/btmc_host_model.sv
`timescale 1ns/100ps

module btmc_host_model (
  input wire logic two_line, // pair option selected
  input wire logic sel, // which line of each function is used
  input wire btmc_pkg::btmc_cmd_s req, // requested command
  output logic [1:0] fwd_n, // forward lines, active low
  output logic [1:0] rev_n, // reverse lines, active low
  output logic [1:0] stop_n // stop lines, active low
);
  always_comb begin
    fwd_n = 2'h3;
    rev_n = 2'h3;
    stop_n = 2'h3;
    if (two_line) begin
      // the pair is always driven, so no request reads as stop 1/1
      fwd_n[0] = ~(req.fwd && !req.stop);
      rev_n[0] = ~(req.rev && !req.stop && !req.fwd);
    end else begin
      fwd_n[sel] = ~req.fwd;
      rev_n[sel] = ~req.rev;
      stop_n[sel] = ~req.stop;
    end
  end
endmodule

// ### sim/testbench.sv
`timescale 1ns/100ps
`include "btmc_params.svh"

module testbench;
  localparam int PCYC = 8;
  logic clk;
  logic nrst;
  logic two_line_mode;
  logic sel;
  btmc_pkg::btmc_cmd_s req;
  logic [1:0] fwd_n;
  logic [1:0] rev_n;
  logic [1:0] stop_n;
  logic run_line;
  logic stop_line;
  logic [2:0] dir_lines;
  logic preset_busy;
  btmc_pkg::btmc_coil_s coils;
  int miscompares;
  int n_compared;

  btmc_host_model host (
    .two_line(two_line_mode), .sel(sel), .req(req),
    .fwd_n(fwd_n), .rev_n(rev_n), .stop_n(stop_n)
  );

  btmc_motion_ctrl #(.PRESET_CYC(PCYC)) dut (
    .clk(clk), .nrst(nrst), .two_line_mode(two_line_mode),
    .fwd_n(fwd_n), .rev_n(rev_n), .stop_n(stop_n),
    .run_line(run_line), .stop_line(stop_line), .dir_lines(dir_lines),
    .preset_busy(preset_busy), .coils(coils)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // idx 3 fwd drive, 2 fwd brake, 1 rev drive, 0 rev brake
  function automatic logic [7:0] coil_on(input int idx);
    logic [7:0] c;
    c = {4{`BTMC_COIL_OFF}};
    c[idx*2 +: 2] = `BTMC_COIL_ON;
    return c;
  endfunction

  // cmd is {fwd, rev, stop}; sync plus state plus coil register take 4 edges
  task automatic step(input logic [2:0] cmd, input logic run, input logic [2:0] dir, input int coil);
    req = cmd;
    tick(4);
    check({3'h0, run_line, stop_line, dir_lines}, {3'h0, run, ~run, dir});
    check(coils, coil_on(coil));
  endtask

  task automatic t_preset();
    check({2'h0, run_line, stop_line, preset_busy, dir_lines}, 8'h1d);
    check(coils, 8'hff);
    nrst = 1'b1;
    req = 3'h2;
    tick(PCYC - 4);
    check({7'h0, preset_busy}, 8'h01);
    req = 3'h0;
    tick(3);
    check({7'h0, preset_busy}, 8'h01);
    tick(1);
    check({7'h0, preset_busy}, 8'h00);
    // reverse asked during the preset must have been refused
    step(3'h0, 1'b0, 3'h5, 2);
  endtask

  task automatic t_three_line();
    sel = 1'b1;
    step(3'h4, 1'b1, 3'h1, 3);
    step(3'h0, 1'b1, 3'h1, 3);
    sel = 1'b0;
    step(3'h1, 1'b0, 3'h5, 2);
    step(3'h2, 1'b1, 3'h4, 1);
    step(3'h4, 1'b1, 3'h1, 3);
    sel = 1'b1;
    step(3'h2, 1'b1, 3'h4, 1);
    step(3'h6, 1'b1, 3'h4, 1);
    step(3'h1, 1'b0, 3'h7, 0);
    step(3'h0, 1'b0, 3'h7, 0);
  endtask

  task automatic t_two_line();
    two_line_mode = 1'b1;
    step(3'h0, 1'b0, 3'h7, 0);
    step(3'h4, 1'b1, 3'h1, 3);
    step(3'h0, 1'b0, 3'h5, 2);
    step(3'h2, 1'b1, 3'h4, 1);
    step(3'h0, 1'b0, 3'h7, 0);
    two_line_mode = 1'b0;
    step(3'h0, 1'b0, 3'h7, 0);
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    miscompares = 0;
    n_compared = 0;
    nrst = 1'b0;
    two_line_mode = 1'b0;
    sel = 1'b0;
    req = '0;
    tick(20);
    t_preset();
    t_three_line();
    t_two_line();
    summarize();
  end

  // tests need about 92 cycles; allow 1000
  initial begin
    #50000;
    miscompares++;
    summarize();
  end
endmodule
